// [src/flash_write_protection.sv]
// write latch, block-range protection, freeze lock and one-time space of a serial flash
// assumes a decoded command stream on core_clk and an axi4-lite master for software
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module flash_write_protection #(
    parameter int ADDR_W = 24
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic porRst_n,
    input wire logic cmdValid,
    input wire flash_protect_pkg::command_type cmd,
    input wire logic sectorGuard,
    output logic cmdDone,
    output logic cmdGranted,
    output logic [7:0] otpReadData,
    output logic writeLatchFlag,
    output logic programFail,
    output logic irq,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    logic [7:0] otpMem [flash_protect_pkg::OTP_BYTES];
    logic [flash_protect_pkg::OTP_ECC_UNITS-1:0] eccUsed;
    logic [flash_protect_pkg::OTP_ECC_UNITS-1:0] eccOff;
    logic [2:0] rangeSize;
    logic rangeOrigin;
    logic freeze;
    logic [flash_protect_pkg::IRQ_W-1:0] irqStatus;
    logic [flash_protect_pkg::IRQ_W-1:0] irqEnable;
    logic [7:0] awAddrHeld;
    logic [31:0] wDataHeld;
    logic [3:0] wStrbHeld;
    logic awHeld;
    logic wHeld;

    // command decode
    wire isLatchSet = cmdValid && cmd.opcode == flash_protect_pkg::LATCH_SET_CMD;
    wire isLatchClr = cmdValid && cmd.opcode == flash_protect_pkg::WRITE_LATCH_CLEAR_CMD;
    wire isRegWrite = cmdValid && cmd.opcode == flash_protect_pkg::REGISTER_WRITE_CMD;
    wire isPage = cmdValid && (cmd.opcode == flash_protect_pkg::PAGE_WRITE_CMD ||
        cmd.opcode == flash_protect_pkg::QUAD_PAGE_WRITE_CMD);
    wire isWipe = cmdValid && cmd.opcode == flash_protect_pkg::BLOCK_WIPE_CMD;
    wire isFullWipe = cmdValid && cmd.opcode == flash_protect_pkg::FULL_CHIP_WIPE_CMD;
    wire isOtpWrite = cmdValid && cmd.opcode == flash_protect_pkg::ONETIME_BYTE_WRITE_CMD;
    wire isOtpRead = cmdValid && cmd.opcode == flash_protect_pkg::ONETIME_READ_CMD;
    wire isSoftReset = cmdValid && cmd.opcode == flash_protect_pkg::SOFT_RESET_CMD;

    // one-time address checks; lock byte per group of eight regions
    wire otpInRange = cmd.addr[ADDR_W-1:10] == '0;
    wire [9:0] otpIdx = cmd.addr[9:0];
    wire [4:0] region = otpIdx[9:5];
    wire [5:0] eccUnit = otpIdx[9:4];
    wire [9:0] lockIdx = flash_protect_pkg::OTP_LOCK_BASE + {8'h00, region[4:3]};
    wire [7:0] lockByte = otpMem[lockIdx];
    // region zero's bit also covers the lock bytes themselves in its upper half
    wire regionLocked = !lockByte[region[2:0]];

    // main-array range: fraction 1/2^(7-code) from top or bottom; code 0 protects nothing
    wire [2:0] rangeShift = 3'h7 - rangeSize;
    wire [ADDR_W-1:0] addrPrefix = cmd.addr[ADDR_W-1:0] >> (ADDR_W[4:0] - {2'h0, rangeShift});
    wire [ADDR_W-1:0] prefixOnes = {ADDR_W{1'b1}} >> (ADDR_W[4:0] - {2'h0, rangeShift});
    wire inTop = addrPrefix == prefixOnes;
    wire inBottom = addrPrefix == '0;
    wire rangeHit = rangeSize == flash_protect_pkg::RANGE_ALL ||
        (rangeSize != flash_protect_pkg::RANGE_NONE && (rangeOrigin ? inBottom : inTop));
    wire mainProtected = rangeHit || sectorGuard;

    // grant decisions; every modifying command needs the latch
    wire otpGo = isOtpWrite && writeLatchFlag && otpInRange && !freeze && !regionLocked;
    wire otpFail = isOtpWrite && writeLatchFlag && otpInRange && (freeze || regionLocked);
    wire pageGo = (isPage || isWipe) && writeLatchFlag && !mainProtected;
    wire fullGo = isFullWipe && writeLatchFlag && !mainProtected &&
        rangeSize == flash_protect_pkg::RANGE_NONE;
    wire regGo = isRegWrite && writeLatchFlag;
    wire anyGo = otpGo || pageGo || fullGo || regGo || isLatchSet || isLatchClr || isOtpRead || isSoftReset;
    // out-of-range one-time writes leave the latch untouched
    wire latchClearing = isSoftReset || isPage || isWipe || isFullWipe || isLatchClr || isRegWrite ||
        (isOtpWrite && otpInRange);
    wire modifyRefused = (isPage || isWipe || isFullWipe || isOtpWrite || isRegWrite) && !anyGo;

    // interrupt sources: refusal, program failure, correction lost
    wire [flash_protect_pkg::IRQ_W-1:0] irqEvents = {otpGo && eccUsed[eccUnit], otpFail, modifyRefused};

    // axi write decode
    wire doWrite = awHeld && wHeld && !bvalid;
    wire wrIrqClear = doWrite && awAddrHeld == flash_protect_pkg::REG_IRQ_CLEAR;
    wire wrIrqEnable = doWrite && awAddrHeld == flash_protect_pkg::REG_IRQ_ENABLE && wStrbHeld[0];
    wire wrMapped = awAddrHeld == flash_protect_pkg::REG_IRQ_CLEAR ||
        awAddrHeld == flash_protect_pkg::REG_IRQ_ENABLE;
    wire [flash_protect_pkg::IRQ_W-1:0] clearMask =
        wrIrqClear && wStrbHeld[0] ? wDataHeld[flash_protect_pkg::IRQ_W-1:0] : '0;
    wire [flash_protect_pkg::IRQ_W-1:0] next_irqStatus = (irqStatus & ~clearMask) | irqEvents;

    // axi read decode
    wire [31:0] statusWord = {25'h000_0000, freeze, rangeOrigin, rangeSize, programFail, writeLatchFlag};
    wire rdStatus = araddr == flash_protect_pkg::REG_STATUS;
    wire rdIrqStatus = araddr == flash_protect_pkg::REG_IRQ_STATUS;
    wire rdIrqClear = araddr == flash_protect_pkg::REG_IRQ_CLEAR;
    wire rdIrqEnable = araddr == flash_protect_pkg::REG_IRQ_ENABLE;
    wire rdEccLo = araddr == flash_protect_pkg::REG_ECC_OFF_LO;
    wire rdEccHi = araddr == flash_protect_pkg::REG_ECC_OFF_HI;
    wire rdMapped = rdStatus || rdIrqStatus || rdIrqClear || rdIrqEnable || rdEccLo || rdEccHi;
    wire [31:0] readMux = rdStatus ? statusWord :
        rdIrqStatus ? {29'h0000_0000, irqStatus} :
        rdIrqEnable ? {29'h0000_0000, irqEnable} :
        rdEccLo ? eccOff[31:0] :
        rdEccHi ? eccOff[63:32] : 32'h0000_0000;

    // one-time bytes: programming only clears bits, only power-on reset sets them back to erased
    genvar gi;
    generate
        for (gi = 0; gi < flash_protect_pkg::OTP_BYTES; gi = gi + 1) begin : otpByte
            always_ff @(posedge core_clk) begin
                if (!porRst_n) begin
                    otpMem[gi] <= flash_protect_pkg::OTP_ERASED;
                end else if (otpGo && otpIdx == 10'(gi)) begin
                    otpMem[gi] <= otpMem[gi] & cmd.data[7:0];
                end
            end
        end
        // correction bookkeeping per 16-byte unit, non-volatile like the bytes
        for (gi = 0; gi < flash_protect_pkg::OTP_ECC_UNITS; gi = gi + 1) begin : eccTrack
            always_ff @(posedge core_clk) begin
                if (!porRst_n) begin
                    eccUsed[gi] <= 1'b0;
                    eccOff[gi] <= 1'b0;
                end else if (otpGo && eccUnit == 6'(gi)) begin
                    eccUsed[gi] <= 1'b1;
                    eccOff[gi] <= eccOff[gi] | eccUsed[gi];
                end
            end
        end
    endgenerate

    // protection settings survive hardware reset; only power-on clears them
    always_ff @(posedge core_clk) begin
        if (!porRst_n) begin
            rangeSize <= flash_protect_pkg::RANGE_NONE;
            rangeOrigin <= 1'b0;
            freeze <= 1'b0;
        end else if (regGo) begin
            if (!freeze) begin
                rangeSize <= cmd.data[flash_protect_pkg::RANGE_LSB +: 3];
                rangeOrigin <= cmd.data[flash_protect_pkg::CFG_ORIGIN_BIT];
            end
            freeze <= freeze | cmd.data[flash_protect_pkg::CFG_FREEZE_BIT];
        end
    end

    // latch, fail flag and command answer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            writeLatchFlag <= 1'b0;
            programFail <= 1'b0;
            cmdDone <= 1'b0;
            cmdGranted <= 1'b0;
            otpReadData <= flash_protect_pkg::OTP_UNDEFINED;
        end else begin
            if (isLatchSet) begin
                writeLatchFlag <= 1'b1;
            end else if (latchClearing) begin
                writeLatchFlag <= 1'b0;
            end
            programFail <= programFail | otpFail;
            cmdDone <= cmdValid;
            cmdGranted <= anyGo;
            if (isOtpRead) begin
                // beyond 1 kB the answer is a fixed filler
                otpReadData <= otpInRange ? otpMem[otpIdx] : flash_protect_pkg::OTP_UNDEFINED;
            end
        end
    end

    // sticky interrupt bits, set beats a same-cycle clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irqStatus <= '0;
            irqEnable <= '0;
            irq <= 1'b0;
        end else begin
            irqStatus <= next_irqStatus;
            if (wrIrqEnable) begin
                irqEnable <= wDataHeld[flash_protect_pkg::IRQ_W-1:0];
            end
            irq <= |(next_irqStatus & (wrIrqEnable ? wDataHeld[flash_protect_pkg::IRQ_W-1:0] : irqEnable));
        end
    end

    // axi write channels, address and data taken in either order
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            awAddrHeld <= 8'h00;
            wDataHeld <= 32'h0000_0000;
            wStrbHeld <= 4'h0;
            bvalid <= 1'b0;
            bresp <= flash_protect_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                awready <= 1'b0;
                awAddrHeld <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                wready <= 1'b0;
                wDataHeld <= wdata;
                wStrbHeld <= wstrb;
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wrMapped ? flash_protect_pkg::RESP_OKAY : flash_protect_pkg::RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // axi read channel, one outstanding read
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= flash_protect_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= readMux;
            rresp <= rdMapped ? flash_protect_pkg::RESP_OKAY : flash_protect_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // checks next to the logic they guard
    latch_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        isLatchSet |=> writeLatchFlag && cmdDone && cmdGranted)
        else $error("latch not set after latch-set command");
    latch_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (isLatchClr || isPage || isFullWipe) |=> !writeLatchFlag)
        else $error("latch still set after clearing command");
    otp_range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        isOtpWrite && writeLatchFlag && !otpInRange |=> writeLatchFlag && !cmdGranted)
        else $error("out-of-range one-time write changed latch");
    freeze_fail_a: assert property (@(posedge core_clk) disable iff (!rst_n || !porRst_n)
        isOtpWrite && writeLatchFlag && otpInRange && freeze |=> programFail && !cmdGranted)
        else $error("frozen one-time write did not fail");
    freeze_sticky_a: assert property (@(posedge core_clk) disable iff (!porRst_n)
        freeze |=> freeze [*2])
        else $error("freeze bit dropped before power-on reset");
    range_hold_a: assert property (@(posedge core_clk) disable iff (!porRst_n || !rst_n)
        freeze && isRegWrite |=> $stable(rangeSize) && $stable(rangeOrigin) && !$rose(programFail))
        else $error("range bits changed while frozen");
    locked_reject_a: assert property (@(posedge core_clk) disable iff (!rst_n || !porRst_n)
        isOtpWrite && otpInRange && regionLocked |=> cmdDone && !cmdGranted && !writeLatchFlag)
        else $error("write to locked region granted");
    all_range_a: assert property (@(posedge core_clk) disable iff (!rst_n || !porRst_n)
        isPage && rangeSize == flash_protect_pkg::RANGE_ALL |=> !cmdGranted)
        else $error("page write granted with whole array protected");
    ecc_second_a: assert property (@(posedge core_clk) disable iff (!porRst_n)
        otpGo && eccUsed[eccUnit] |=> eccOff[$past(eccUnit)])
        else $error("second program kept correction enabled");
    guard_or_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (isPage || isWipe) && sectorGuard |=> !cmdGranted)
        else $error("per-sector guard ignored");

    // programming may only clear bits; a set bit would mean an erase slipped in
    otp_no_erase_a: assert property (@(posedge core_clk) disable iff (!porRst_n)
        otpGo |=> (otpMem[$past(otpIdx)] & ~$past(otpMem[otpIdx])) == 8'h00)
        else $error("one-time byte gained a set bit");

    // an open region with the latch set and no freeze must be written
    open_region_a: assert property (@(posedge core_clk) disable iff (!rst_n || !porRst_n)
        isOtpWrite && writeLatchFlag && otpInRange && !freeze && !regionLocked |=> cmdGranted)
        else $error("write to open region refused");

    // a full wipe would reach protected sectors, so any range refuses it
    full_wipe_a: assert property (@(posedge core_clk) disable iff (!rst_n || !porRst_n)
        isFullWipe && rangeSize != flash_protect_pkg::RANGE_NONE |=> !cmdGranted)
        else $error("full wipe granted with range protection");
endmodule

// [shared/flash_protect_pkg.sv]
// constants and carrier types for the flash write-protection block
// assumes one core clock; commands arrive already decoded from the serial front end
package flash_protect_pkg;
    // command opcodes
    localparam logic [7:0] LATCH_SET_CMD = 8'h06;
    localparam logic [7:0] WRITE_LATCH_CLEAR_CMD = 8'h04;
    localparam logic [7:0] REGISTER_WRITE_CMD = 8'h01;
    localparam logic [7:0] PAGE_WRITE_CMD = 8'h02;
    localparam logic [7:0] QUAD_PAGE_WRITE_CMD = 8'h32;
    localparam logic [7:0] BLOCK_WIPE_CMD = 8'hD8;
    localparam logic [7:0] FULL_CHIP_WIPE_CMD = 8'h60;
    localparam logic [7:0] ONETIME_BYTE_WRITE_CMD = 8'h42;
    localparam logic [7:0] ONETIME_READ_CMD = 8'h4B;
    localparam logic [7:0] SOFT_RESET_CMD = 8'hF0;
    // one-time space geometry
    localparam int OTP_BYTES = 1024;
    localparam int OTP_REGIONS = 32;
    localparam int OTP_ECC_UNITS = 64;
    localparam logic [9:0] OTP_LOCK_BASE = 10'h010;
    localparam logic [7:0] OTP_ERASED = 8'hFF;
    localparam logic [7:0] OTP_UNDEFINED = 8'hFF;
    // register-write payload: low byte first status, high byte configuration
    localparam int RANGE_LSB = 2;
    localparam int CFG_FREEZE_BIT = 8;
    localparam int CFG_ORIGIN_BIT = 13;
    localparam logic [2:0] RANGE_ALL = 3'h7;
    localparam logic [2:0] RANGE_NONE = 3'h0;
    // axi4-lite register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_CLEAR = 8'h08;
    localparam logic [7:0] REG_IRQ_ENABLE = 8'h0C;
    localparam logic [7:0] REG_ECC_OFF_LO = 8'h10;
    localparam logic [7:0] REG_ECC_OFF_HI = 8'h14;
    localparam int IRQ_W = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [15:0] data;
    } command_type;
endpackage

// [testbench/flash_host_model.sv]
// host-side command source for the write-protection block
// assumes the block answers each command with cmdDone exactly one cycle later
`timescale 1ns/100ps
module flash_host_model (
    input wire logic core_clk,
    input wire logic cmdDone,
    input wire logic cmdGranted,
    output logic cmdValid,
    output flash_protect_pkg::command_type cmd
);
    initial begin
        cmdValid = 1'b0;
        cmd = '0;
    end
    // one command per call; fields flip when idle so nothing leans on stale values
    task automatic issue(input logic [7:0] op, input logic [23:0] a, input logic [15:0] d, output logic ok);
        @(posedge core_clk);
        cmdValid <= 1'b1;
        cmd <= '{opcode: op, addr: a, data: d};
        @(posedge core_clk);
        cmdValid <= 1'b0;
        cmd <= ~cmd;
        #1;
        ok = (cmdDone === 1'b1) ? cmdGranted : 1'bx;
    endtask
    // modifying commands always go out behind a latch set
    task automatic guarded(input logic [7:0] op, input logic [23:0] a, input logic [15:0] d, output logic ok);
        logic g;
        issue(flash_protect_pkg::LATCH_SET_CMD, 24'h00_0000, 16'h0000, g);
        issue(op, a, d, ok);
    endtask
endmodule

// [testbench/flash_write_protection_bench.sv]
// self-checking bench for the flash write-protection block
// assumes a 20 MHz core clock; software access goes over axi4-lite
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module flash_write_protection_bench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic porRst_n = 1'b0;
    logic sectorGuard = 1'b0;
    logic cmdValid, cmdDone, cmdGranted, writeLatchFlag, programFail, irq, g;
    flash_protect_pkg::command_type cmd;
    logic [7:0] otpReadData, awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, rsp;
    int n_fail = 0;
    int n_compared = 0;

    flash_write_protection dut (.core_clk(core_clk), .rst_n(rst_n), .porRst_n(porRst_n), .cmdValid(cmdValid),
        .cmd(cmd), .sectorGuard(sectorGuard), .cmdDone(cmdDone), .cmdGranted(cmdGranted),
        .otpReadData(otpReadData), .writeLatchFlag(writeLatchFlag), .programFail(programFail), .irq(irq),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    flash_host_model host (.core_clk(core_clk), .cmdDone(cmdDone), .cmdGranted(cmdGranted), .cmdValid(cmdValid),
        .cmd(cmd));

    // 50 ns period
    always #25 core_clk = ~core_clk;

    // axi write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic st(input logic [31:0] e);
        axi_rd(flash_protect_pkg::REG_STATUS, rd, rsp);
        `CHK(rd, e)
    endtask
    // por selects the power-on reset as well as the hardware one
    task automatic do_reset(input logic por);
        @(posedge core_clk);
        rst_n <= 1'b0;
        porRst_n <= ~por;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        porRst_n <= 1'b1;
    endtask

    task automatic t_latch();
        logic [7:0] ops [7];
        ops = '{flash_protect_pkg::PAGE_WRITE_CMD, flash_protect_pkg::QUAD_PAGE_WRITE_CMD,
            flash_protect_pkg::BLOCK_WIPE_CMD, flash_protect_pkg::FULL_CHIP_WIPE_CMD,
            flash_protect_pkg::REGISTER_WRITE_CMD, flash_protect_pkg::ONETIME_BYTE_WRITE_CMD,
            flash_protect_pkg::SOFT_RESET_CMD};
        `CHK(writeLatchFlag, 1'b0)
        host.issue(flash_protect_pkg::PAGE_WRITE_CMD, 24'h00_0100, 16'h0000, g);
        `CHK(g, 1'b0)
        host.issue(flash_protect_pkg::LATCH_SET_CMD, 24'h00_0000, 16'h0000, g);
        `CHK(writeLatchFlag, 1'b1)
        host.issue(flash_protect_pkg::WRITE_LATCH_CLEAR_CMD, 24'h00_0000, 16'h0000, g);
        `CHK(writeLatchFlag, 1'b0)
        foreach (ops[i]) begin
            host.guarded(ops[i], 24'h00_0100, 16'h0000, g);
            `CHK({g, writeLatchFlag}, 2'b10)
        end
    endtask
    // second program of a 16-byte unit ands the data in and drops correction
    task automatic t_otp();
        host.guarded(flash_protect_pkg::ONETIME_BYTE_WRITE_CMD, 24'h00_0020, 16'h005A, g);
        host.guarded(flash_protect_pkg::ONETIME_BYTE_WRITE_CMD, 24'h00_0020, 16'h000F, g);
        host.issue(flash_protect_pkg::ONETIME_READ_CMD, 24'h00_0020, 16'h0000, g);
        `CHK(otpReadData, 8'h0A)
        axi_rd(flash_protect_pkg::REG_ECC_OFF_LO, rd, rsp);
        `CHK(rd, 32'h0000_0004)
        host.issue(flash_protect_pkg::ONETIME_READ_CMD, 24'h00_03FF, 16'h0000, g);
        `CHK(otpReadData, 8'hFF)
        host.guarded(flash_protect_pkg::ONETIME_BYTE_WRITE_CMD, 24'h00_0400, 16'h0000, g);
        `CHK({writeLatchFlag, programFail}, 2'b10)
        host.issue(flash_protect_pkg::ONETIME_READ_CMD, 24'h00_0400, 16'h0000, g);
        `CHK(otpReadData, flash_protect_pkg::OTP_UNDEFINED)
    endtask
    // two addresses straddle each range boundary for every code and origin
    task automatic t_block();
        int sz;
        int a;
        logic prot;
        for (int o = 0; o < 2; o++) begin
            for (int c = 0; c < 8; c++) begin
                sz = (c == 0) ? 0 : (1 << (17 + c));
                host.guarded(flash_protect_pkg::REGISTER_WRITE_CMD, 24'h00_0000, 16'(o << 13 | c << 2), g);
                for (int k = 0; k < 2; k++) begin
                    a = (o == 1) ? sz - 1 + k : 16777216 - sz - k;
                    a = a & 32'h00FF_FFFF;
                    prot = (o == 1) ? (a < sz) : (a >= 16777216 - sz);
                    host.guarded(flash_protect_pkg::PAGE_WRITE_CMD, a[23:0], 16'h0000, g);
                    `CHK(g, !prot)
                end
            end
        end
        st(32'h0000_003C);
        // range cleared first so only the per-sector guard acts
        host.guarded(flash_protect_pkg::REGISTER_WRITE_CMD, 24'h00_0000, 16'h0000, g);
        @(posedge core_clk);
        sectorGuard <= 1'b1;
        host.guarded(flash_protect_pkg::PAGE_WRITE_CMD, 24'h00_0100, 16'h0000, g);
        `CHK(g, 1'b0)
        host.guarded(flash_protect_pkg::BLOCK_WIPE_CMD, 24'h00_0100, 16'h0000, g);
        `CHK(g, 1'b0)
        sectorGuard <= 1'b0;
        host.guarded(flash_protect_pkg::PAGE_WRITE_CMD, 24'h00_0100, 16'h0000, g);
        `CHK(g, 1'b1)
    endtask
    task automatic t_freeze();
        host.guarded(flash_protect_pkg::REGISTER_WRITE_CMD, 24'h00_0000, 16'h010C, g);
        st(32'h0000_004C);
        host.guarded(flash_protect_pkg::REGISTER_WRITE_CMD, 24'h00_0000, 16'h2000, g);
        st(32'h0000_004C);
        do_reset(1'b0);
        st(32'h0000_004C);
        host.guarded(flash_protect_pkg::ONETIME_BYTE_WRITE_CMD, 24'h00_0200, 16'h0000, g);
        `CHK({g, programFail}, 2'b01)
        do_reset(1'b1);
        st(32'h0000_0000);
    endtask
    // lock byte 0x10 = 0x7C locks regions 0, 1 and 7; 0x11 bit 0 locks region 8
    task automatic t_lock();
        logic [23:0] la [6] = '{24'h00_0018, 24'h00_0020, 24'h00_00E0, 24'h00_0100, 24'h00_0040, 24'h00_0120};
        logic [5:0] lg = 6'b11_0000;
        host.guarded(flash_protect_pkg::ONETIME_BYTE_WRITE_CMD, 24'h00_0011, 16'h00FE, g);
        host.guarded(flash_protect_pkg::ONETIME_BYTE_WRITE_CMD, 24'h00_0010, 16'h007C, g);
        for (int i = 0; i < 6; i++) begin
            host.guarded(flash_protect_pkg::ONETIME_BYTE_WRITE_CMD, la[i], 16'h0000, g);
            `CHK(g, lg[i])
        end
        host.issue(flash_protect_pkg::ONETIME_READ_CMD, 24'h00_0020, 16'h0000, g);
        `CHK({otpReadData, programFail}, 9'h1FF)
    endtask
    // irq follows the enabled failure bit in the same cycle, without lag
    task automatic t_irq();
        `CHK(irq, 1'b0)
        axi_wr(flash_protect_pkg::REG_IRQ_ENABLE, 32'h0000_0002, rsp);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b1)
        axi_wr(flash_protect_pkg::REG_IRQ_CLEAR, 32'h0000_0007, rsp);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b0)
        axi_rd(flash_protect_pkg::REG_IRQ_ENABLE, rd, rsp);
        `CHK({rd, rsp}, {32'h0000_0002, flash_protect_pkg::RESP_OKAY})
        axi_rd(flash_protect_pkg::REG_IRQ_CLEAR, rd, rsp);
        `CHK({rd, rsp}, {32'h0000_0000, flash_protect_pkg::RESP_OKAY})
        axi_rd(8'h20, rd, rsp);
        `CHK({rd, rsp}, {32'h0000_0000, flash_protect_pkg::RESP_SLVERR})
        axi_wr(flash_protect_pkg::REG_STATUS, 32'h0000_0000, rsp);
        `CHK(rsp, flash_protect_pkg::RESP_SLVERR)
    endtask

    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // the whole sequence needs well under 2000 cycles
    initial begin
        #1_000_000;
        n_fail++;
        close_out();
    end
    initial begin
        do_reset(1'b1);
        t_latch();
        t_otp();
        t_block();
        t_freeze();
        t_lock();
        t_irq();
        close_out();
    end
endmodule
